// ==== inc/fop_pkg.sv ====
// constants for the flash overlay host controller: register map, fields, timing
// assumes a 10 MHz core clock and a x16 asynchronous nor flash on the pins
package fop_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_MHZ       = 10;
  localparam int T_SETUP_NS    = 20;
  localparam int T_WPULSE_NS   = 100;
  localparam int T_ACCESS_NS   = 100;
  localparam int T_RPULSE_NS   = 500;
  localparam int T_POR_US      = 300;
  // least times round up, so any nonzero time gives at least one cycle
  localparam int SETUP_CYC     = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int WPULSE_CYC    = (T_WPULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int ACCESS_CYC    = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int RPULSE_CYC    = (T_RPULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int POR_CYC       = T_POR_US * CLK_MHZ;
  localparam int SYNC_CYC      = 2;
  localparam int CNT_W         = 12;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_ADDR     = 8'h04;
  localparam logic [7:0] OFS_WDATA    = 8'h08;
  localparam logic [7:0] OFS_RDATA    = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

  // ****************************************************************
  // fields
  // ****************************************************************
  localparam int CTRL_GO       = 0;
  localparam int CTRL_WRITE    = 1;
  localparam int CTRL_HWRST    = 2;
  localparam int CTRL_OVL_LSB  = 4;
  localparam int ADDR_CMD_FMT  = 31;
  localparam int SECT_LSB      = 16;
  localparam int PAT_MSB       = 10;
  localparam int ST_BUSY       = 0;
  localparam int ST_READY      = 1;
  localparam int ST_UNDEF      = 2;
  localparam int ST_BLOCKED    = 3;
  localparam int ST_REFUSED    = 4;
  localparam int IRQ_DONE      = 0;
  localparam int IRQ_REFUSED   = 1;
  localparam int IRQ_W         = 2;
  localparam int ADDR_W        = 26;
  localparam int DQ_W          = 16;

  // ****************************************************************
  // overlay map figures
  // ****************************************************************
  localparam logic [25:0] OTP_LIMIT    = 26'h000_0200;
  localparam logic [25:0] PWD_WORDS    = 26'h000_0004;
  localparam logic [15:0] ECC_MASK     = 16'h0006;
  localparam logic [15:0] BIT0_MASK    = 16'h0001;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    OVL_ARRAY    = 3'h0,
    OVL_OTP      = 3'h1,
    OVL_LOCKWORD = 3'h2,
    OVL_NVBIT    = 3'h3,
    OVL_GUARD    = 3'h4,
    OVL_PASSWORD = 3'h5,
    OVL_VBIT     = 3'h6,
    OVL_ECC      = 3'h7
  } fop_ovl_e;

  typedef enum logic [5:0] {
    ST_POR    = 6'b000001,
    ST_IDLE   = 6'b000010,
    ST_SETUP  = 6'b000100,
    ST_STROBE = 6'b001000,
    ST_HOLD   = 6'b010000,
    ST_RST    = 6'b100000
  } fop_state_e;

endpackage

// ==== hw/fop_host.sv ====
// host controller for a parallel nor flash: single word cycles, overlay aware
// assumes an axi4-lite master on core_clk and the flash pins wired directly
`timescale 1ns/1ns

// Function
// - lock word accessed only at location zero
// - ecc overlay entered only from read mode
// - hardware reset pulse recovers unknown state
// - command address: sector high, pattern low
module fop_host (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // interrupt
  output logic             irq,
  // supply supervisor
  input  wire logic        supply_low,
  // flash pins
  output logic [25:0]      flash_addr,
  output logic [15:0]      flash_dq_out,
  input  wire logic [15:0] flash_dq_in,
  output logic             flash_dq_oe_n,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  output logic             flash_reset_n
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  fop_pkg::fop_state_e         state;
  fop_pkg::fop_ovl_e           ovl, new_ovl;
  logic [fop_pkg::CNT_W-1:0]   cnt;
  logic [31:0]                 addr_reg;
  logic [15:0]                 wdata_reg, rdata_reg, dq_s1, dq_s2;
  logic                        op_write, undef_flag, blocked_flag, refused_flag, low_s1, low_s2;
  logic                        wr_take, ctrl_wr, go_req, go_ok, ecc_bad;
  logic [fop_pkg::IRQ_W-1:0]   irq_stat, irq_mask, irq_set, irq_clr;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [25:0] pin_addr(input logic [31:0] a, input fop_pkg::fop_ovl_e o);
    logic [25:0] r;
    r = a[25:0];
    if (a[fop_pkg::ADDR_CMD_FMT]) r = {a[25:fop_pkg::SECT_LSB], 5'h00, a[fop_pkg::PAT_MSB:0]};
    if (o == fop_pkg::OVL_LOCKWORD) r = 26'h000_0000;
    return r;
  endfunction

  function automatic logic [15:0] mask_data(input logic [15:0] d, input fop_pkg::fop_ovl_e o);
    case (o)
      fop_pkg::OVL_NVBIT, fop_pkg::OVL_GUARD, fop_pkg::OVL_VBIT: mask_data = d & fop_pkg::BIT0_MASK;
      fop_pkg::OVL_ECC: mask_data = d & fop_pkg::ECC_MASK;
      default: mask_data = d;
    endcase
  endfunction

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dq_s1  <= 16'h0000;
      dq_s2  <= 16'h0000;
      low_s1 <= 1'b1;
      low_s2 <= 1'b1;
    end else begin
      dq_s1  <= flash_dq_in;
      dq_s2  <= dq_s1;
      low_s1 <= supply_low;
      low_s2 <= low_s1;
    end
  end

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  // ready pulses one cycle once both address and data wait, so either arrival order works
  assign wr_take = s_axi_awvalid & s_axi_wvalid & s_axi_awready & s_axi_wready;
  assign ctrl_wr = wr_take & (s_axi_awaddr == fop_pkg::OFS_CTRL) & s_axi_wstrb[0];
  assign go_req  = ctrl_wr & s_axi_wdata[fop_pkg::CTRL_GO];
  assign new_ovl = fop_pkg::fop_ovl_e'(s_axi_wdata[fop_pkg::CTRL_OVL_LSB+:3]);
  // ecc overlay may only be declared from plain read mode
  assign ecc_bad = ctrl_wr & (new_ovl == fop_pkg::OVL_ECC) & (ovl != fop_pkg::OVL_ARRAY) & (ovl != fop_pkg::OVL_ECC);
  // writes need the supply good; nothing at all while power-on wait runs
  assign go_ok   = (state == fop_pkg::ST_IDLE) & ~ecc_bad & ~(s_axi_wdata[fop_pkg::CTRL_WRITE] & low_s2);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= fop_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (s_axi_awaddr > fop_pkg::OFS_IRQ_MASK || s_axi_awaddr[1:0] != 2'h0)
                        ? fop_pkg::RESP_SLVERR : fop_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= fop_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= fop_pkg::RESP_OKAY;
        case (s_axi_araddr)
          fop_pkg::OFS_CTRL:     s_axi_rdata <= {25'h000_0000, ovl, 4'h0};
          fop_pkg::OFS_ADDR:     s_axi_rdata <= addr_reg;
          fop_pkg::OFS_WDATA:    s_axi_rdata <= {16'h0000, wdata_reg};
          fop_pkg::OFS_RDATA:    s_axi_rdata <= {16'h0000, rdata_reg};
          fop_pkg::OFS_STATUS:   s_axi_rdata <= {27'h000_0000, refused_flag, blocked_flag, undef_flag,
                                                 (state != fop_pkg::ST_POR) & (state != fop_pkg::ST_RST),
                                                 (state != fop_pkg::ST_IDLE)};
          fop_pkg::OFS_IRQ_STAT: s_axi_rdata <= {30'h0000_0000, irq_stat};
          fop_pkg::OFS_IRQ_MASK: s_axi_rdata <= {30'h0000_0000, irq_mask};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= fop_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // software registers
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      addr_reg  <= 32'h0000_0000;
      wdata_reg <= 16'h0000;
      irq_mask  <= 2'h0;
    end else if (wr_take) begin
      if (s_axi_awaddr == fop_pkg::OFS_ADDR) addr_reg <= s_axi_wdata;
      if (s_axi_awaddr == fop_pkg::OFS_WDATA) wdata_reg <= s_axi_wdata[15:0];
      if (s_axi_awaddr == fop_pkg::OFS_IRQ_MASK) irq_mask <= s_axi_wdata[fop_pkg::IRQ_W-1:0];
    end
  end

  // overlay in force; hardware reset and power-on bring back plain array reads
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ovl <= fop_pkg::OVL_ARRAY;
    end else if (state == fop_pkg::ST_RST) begin
      ovl <= fop_pkg::OVL_ARRAY;
    end else if (ctrl_wr & ~ecc_bad) begin
      ovl <= new_ovl;
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  assign irq_set = {go_req & ~go_ok, (state == fop_pkg::ST_HOLD) & (cnt == '0)};
  assign irq_clr = (wr_take & (s_axi_awaddr == fop_pkg::OFS_IRQ_STAT)) ? s_axi_wdata[fop_pkg::IRQ_W-1:0] : 2'h0;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_stat <= 2'h0;
      irq      <= 1'b0;
    end else begin
      // a new event wins over a clear in the same cycle
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      irq      <= |(((irq_stat & ~irq_clr) | irq_set) & irq_mask);
    end
  end

  // ****************************************************************
  // flash cycle sequencer
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state        <= fop_pkg::ST_POR;
      cnt          <= fop_pkg::CNT_W'(fop_pkg::POR_CYC - 1);
      op_write     <= 1'b0;
      refused_flag <= 1'b0;
    end else begin
      if (go_req) begin
        refused_flag <= ~go_ok;
      end
      // one shared down-counter; a state that loads it overrides the step
      if (cnt != '0) cnt <= cnt - 1'b1;
      case (state)
        // pins stay idle until the device is through its power-on time
        fop_pkg::ST_POR: if (cnt == '0) state <= fop_pkg::ST_IDLE;
        fop_pkg::ST_IDLE: begin
          if (ctrl_wr & s_axi_wdata[fop_pkg::CTRL_HWRST]) begin
            state <= fop_pkg::ST_RST;
            cnt   <= fop_pkg::CNT_W'(fop_pkg::RPULSE_CYC - 1);
          end else if (go_req & go_ok) begin
            state    <= fop_pkg::ST_SETUP;
            op_write <= s_axi_wdata[fop_pkg::CTRL_WRITE];
            cnt      <= fop_pkg::CNT_W'(fop_pkg::SETUP_CYC - 1);
          end
        end
        fop_pkg::ST_SETUP: begin
          if (cnt == '0) begin
            state <= fop_pkg::ST_STROBE;
            cnt   <= op_write ? fop_pkg::CNT_W'(fop_pkg::WPULSE_CYC - 1)
                              : fop_pkg::CNT_W'(fop_pkg::ACCESS_CYC + fop_pkg::SYNC_CYC - 1);
          end
        end
        fop_pkg::ST_STROBE: if (cnt == '0) state <= fop_pkg::ST_HOLD;
        fop_pkg::ST_HOLD: state <= fop_pkg::ST_IDLE;
        fop_pkg::ST_RST: begin
          if (cnt == '0) begin
            state <= fop_pkg::ST_POR;
            cnt   <= fop_pkg::CNT_W'(fop_pkg::POR_CYC - 1);
          end
        end
        default: begin
          state <= fop_pkg::ST_IDLE;
          cnt   <= '0;
        end
      endcase
    end
  end

  // read capture: data taken from the second synchroniser stage at the strobe end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_reg    <= 16'h0000;
      undef_flag   <= 1'b0;
      blocked_flag <= 1'b0;
    end else if ((state == fop_pkg::ST_STROBE) & (cnt == '0) & ~op_write) begin
      rdata_reg    <= mask_data(dq_s2, ovl);
      undef_flag   <= ((ovl == fop_pkg::OVL_OTP) & (addr_reg[15:0] >= fop_pkg::OTP_LIMIT[15:0]))
                      | ((ovl == fop_pkg::OVL_PASSWORD) & (addr_reg[25:0] >= fop_pkg::PWD_WORDS));
      blocked_flag <= ((ovl == fop_pkg::OVL_NVBIT) | (ovl == fop_pkg::OVL_VBIT)) & ~dq_s2[0];
    end
  end

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flash_addr    <= 26'h000_0000;
      flash_dq_out  <= 16'h0000;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_reset_n <= 1'b1;
    end else begin
      // low from the accepting edge on, so the pulse spans the full reset count
      flash_reset_n <= ~((state == fop_pkg::ST_RST) & (cnt != '0)
                         | (state == fop_pkg::ST_IDLE) & ctrl_wr & s_axi_wdata[fop_pkg::CTRL_HWRST]);
      if (state == fop_pkg::ST_IDLE && go_req && go_ok) begin
        flash_addr    <= pin_addr(addr_reg, ovl);
        flash_dq_out  <= wdata_reg;
        flash_dq_oe_n <= ~s_axi_wdata[fop_pkg::CTRL_WRITE];
        flash_ce_n    <= 1'b0;
      end else if (state == fop_pkg::ST_SETUP && cnt == '0) begin
        flash_we_n <= ~op_write;
        flash_oe_n <= op_write;
      end else if (state == fop_pkg::ST_STROBE && cnt == '0) begin
        flash_we_n <= 1'b1;
        flash_oe_n <= 1'b1;
      end else if (state == fop_pkg::ST_HOLD) begin
        flash_ce_n    <= 1'b1;
        flash_dq_oe_n <= 1'b1;
      end
    end
  end

endmodule

// ==== testbench/fop_host_checker.sv ====
// checker for the flash host controller: pin framing, power-on quiet, supply lockout, write handshake
// assumes it is bound into fop_host and sees that module's ports only
`timescale 1ns/1ns
module fop_host_checker (
  // clock, reset and supply
  input wire logic core_clk, rst_n, supply_low,
  // axi write handshake
  input wire logic s_axi_awready, s_axi_wready, s_axi_bvalid,
  // flash pins
  input wire logic flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe_n, flash_reset_n
);
  // ****************************************************************
  // helper logic
  // ****************************************************************
  logic [11:0] quiet_cnt;
  // restarts on either reset; stops ten cycles short of the ready point to leave margin
  always_ff @(posedge core_clk) begin
    if (!rst_n || !flash_reset_n) quiet_cnt <= 12'h000;
    else if (quiet_cnt < 12'hbae) quiet_cnt <= quiet_cnt + 12'h001;
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_read_strobe;
    !flash_oe_n [*3] ##1 flash_oe_n;
  endsequence
  sequence s_reset_pulse;
    !flash_reset_n [*5] ##1 flash_reset_n;
  endsequence
  property p_por_quiet;
    quiet_cnt < 12'hbae |-> flash_ce_n && flash_we_n && flash_oe_n && flash_dq_oe_n;
  endproperty
  property p_supply;
    supply_low [*6] |-> flash_we_n;
  endproperty
  property p_we_pulse;
    $fell(flash_we_n) |-> !flash_ce_n && !flash_dq_oe_n ##1 flash_we_n && !flash_ce_n;
  endproperty
  property p_read_strobe;
    $fell(flash_oe_n) |-> s_read_strobe;
  endproperty
  property p_oe_ce;
    !flash_oe_n |-> !flash_ce_n && flash_dq_oe_n && flash_we_n;
  endproperty
  property p_hwrst;
    $fell(flash_reset_n) |-> flash_ce_n throughout s_reset_pulse;
  endproperty
  property p_ce_frame;
    $rose(flash_ce_n) |-> $past(flash_we_n) && $past(flash_oe_n);
  endproperty
  property p_ready_pair;
    s_axi_awready |-> s_axi_wready;
  endproperty
  property p_bvalid_after;
    $rose(s_axi_bvalid) |-> $past(s_axi_awready);
  endproperty
  a_por_quiet: assert property (p_por_quiet) else $error("pins active during power-on wait");
  a_supply: assert property (p_supply) else $error("write strobe while supply low");
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe badly framed");
  a_read_strobe: assert property (p_read_strobe) else $error("read strobe not three cycles");
  a_oe_ce: assert property (p_oe_ce) else $error("read strobe outside select or with bus driven");
  a_hwrst: assert property (p_hwrst) else $error("reset pulse length or select wrong");
  a_ce_frame: assert property (p_ce_frame) else $error("select dropped before strobe");
  a_ready_pair: assert property (p_ready_pair) else $error("address ready without data ready");
  a_bvalid_after: assert property (p_bvalid_after) else $error("write answer without handshake");
endmodule

bind fop_host fop_host_checker i_chk (.core_clk, .rst_n, .supply_low, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_oe_n, .flash_reset_n);

// ==== testbench/fop_flash_model.sv ====
// behavioural x16 nor flash: overlays, protection bits, write lockout
// assumes the host pins of fop_host; reads are combinational, commands act on the write strobe's rise
`timescale 1ns/1ns
module fop_flash_model #(
  parameter logic [7:0]  ENTRY_TAG = 8'ha0,
  parameter logic [15:0] EXIT_CMD  = 16'h00f0,
  parameter logic [15:0] LOCK_WORD = 16'h3c3c
) (
  // host pins
  input  wire logic [25:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  output logic      [15:0] flash_dq_in,
  input  wire logic        flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n,
  // supply supervisor
  input  wire logic        supply_low
);
  logic [2:0]    ovl;
  logic [9:0]    sel, sec;
  logic [15:0]   a, rd, last;
  logic [1023:0] vbit;
  logic          guard;
  assign sec = flash_addr[25:16];
  assign a   = flash_addr[15:0];
  initial begin
    ovl   = 3'h0;
    vbit  = '1;
    guard = 1'b1;
    sel   = 10'h000;
    last  = 16'h0000;
  end
  always_comb begin
    case (ovl)
      3'h1: rd = (sec == sel && a < 16'h0200) ? (16'hc000 | a) : ~a;
      3'h2: rd = LOCK_WORD;
      3'h3: rd = {a[15:1], sec != 10'h001};
      3'h4: rd = {a[15:1], guard};
      3'h5: rd = (flash_addr < 26'h000_0004) ? (16'hd000 | a) : ~a;
      3'h6: rd = {a[15:1], vbit[sec]};
      3'h7: rd = {a[15:3], flash_addr[5:4], 1'b1};
      default: rd = a ^ 16'h5a5a;
    endcase
  end
  // a released bus shows the inverse of the last word, so a stale capture cannot pass
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n && flash_reset_n) ? rd : ~last;
  always @(posedge flash_oe_n) last <= rd;
  always @(negedge flash_reset_n) begin
    ovl   <= 3'h0;
    vbit  <= '1;
    guard <= 1'b1;
  end
  always @(posedge flash_we_n) begin
    if (!flash_ce_n && flash_reset_n && !supply_low) begin
      if (flash_dq_out[15:8] == ENTRY_TAG && (flash_dq_out[2:0] != 3'h7 || ovl == 3'h0)) begin
        ovl <= flash_dq_out[2:0];
        sel <= sec;
      end else if (flash_dq_out == EXIT_CMD) begin
        ovl <= 3'h0;
      end else if (ovl == 3'h6) begin
        vbit[sec] <= flash_dq_out[0];
      end
    end
  end
endmodule

// ==== testbench/fop_host_bench.sv ====
// self-checking bench for fop_host: axi4-lite register tasks driving flash cycles into a behavioural flash
// assumes fop_host_checker is bound in and fop_flash_model sits on the flash pins
`timescale 1ns/1ns
module fop_host_bench;
  typedef struct packed {
    logic [2:0]  o;
    logic [25:0] a;
    logic [15:0] d;
    logic [1:0]  f;
  } fop_row_s;
  localparam logic [7:0]  ENTRY  = 8'ha0;
  localparam logic [15:0] EXIT   = 16'h00f0;
  localparam int          N_ROWS = 14;
  // overlay, address, expected word, expected {blocked, undefined}
  localparam fop_row_s ROWS [N_ROWS] = '{
    '{3'h0, 26'h000_0123, 16'h5b79, 2'h0}, '{3'h1, 26'h003_0010, 16'hc010, 2'h0},
    '{3'h1, 26'h003_01ff, 16'hc1ff, 2'h0}, '{3'h1, 26'h003_0200, 16'h0000, 2'h1},
    '{3'h2, 26'h001_2345, 16'h3c3c, 2'h0}, '{3'h3, 26'h001_0040, 16'h0000, 2'h2},
    '{3'h3, 26'h002_0006, 16'h0001, 2'h0}, '{3'h4, 26'h000_0abc, 16'h0001, 2'h0},
    '{3'h5, 26'h000_0002, 16'hd002, 2'h0}, '{3'h5, 26'h000_0004, 16'h0000, 2'h1},
    '{3'h6, 26'h002_0008, 16'h0001, 2'h0}, '{3'h7, 26'h000_0030, 16'h0006, 2'h0},
    '{3'h7, 26'h000_0010, 16'h0002, 2'h0}, '{3'h0, 26'h000_0123, 16'h5b79, 2'h0}};
  logic        core_clk, rst_n, supply_low, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [25:0] flash_addr, we_addr;
  logic [15:0] flash_dq_out, flash_dq_in;
  logic        flash_dq_oe_n, flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n;
  logic [2:0]  cur;
  int          miscompares, n_tests, cyc;
  fop_host i_dut (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .supply_low, .flash_addr,
    .flash_dq_out, .flash_dq_in, .flash_dq_oe_n, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_n);
  fop_flash_model #(.ENTRY_TAG(ENTRY), .EXIT_CMD(EXIT), .LOCK_WORD(16'h3c3c)) i_flash (.flash_addr,
    .flash_dq_out, .flash_dq_in, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_n, .supply_low);
  // ****************************************************************
  // clock, watchdog, tasks
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(negedge flash_we_n) we_addr = flash_addr;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic pa, pw, ta, tw;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // address and data are released independently as each is taken
    while (pa || pw) begin
      @(negedge core_clk);
      ta = pa && s_axi_awready === 1'b1;
      tw = pw && s_axi_wready === 1'b1;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    s_axi_bready <= 1'b1;
    do @(negedge core_clk); while (s_axi_bvalid !== 1'b1);
    chk("write response", 32'(er), 32'(s_axi_bresp));
    @(posedge core_clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge core_clk); while (s_axi_arready !== 1'b1);
    @(posedge core_clk);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(negedge core_clk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge core_clk);
    s_axi_rready <= 1'b0;
  endtask
  // one flash cycle; leaves the final status word in d
  task automatic go(input logic [2:0] o, input logic [2:0] op, input logic [31:0] a, input logic [15:0] v);
    wr(fop_pkg::OFS_ADDR, a, fop_pkg::RESP_OKAY);
    wr(fop_pkg::OFS_WDATA, {16'h0000, v}, fop_pkg::RESP_OKAY);
    wr(fop_pkg::OFS_CTRL, {25'h000_0000, o, 1'b0, op}, fop_pkg::RESP_OKAY);
    do rd(fop_pkg::OFS_STATUS, d, r); while (d[fop_pkg::ST_BUSY] !== 1'b0);
  endtask
  task automatic wait_ready();
    do rd(fop_pkg::OFS_STATUS, d, r); while (d[fop_pkg::ST_READY] !== 1'b1);
  endtask
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    {rst_n, supply_low, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0000, 32'h0000_0000, 4'hf};
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(fop_pkg::OFS_STATUS, d, r);
    chk("ready at power-on", 32'h0000_0000, 32'(d[fop_pkg::ST_READY]));
    wr(fop_pkg::OFS_CTRL, 32'h0000_0001, fop_pkg::RESP_OKAY);
    rd(fop_pkg::OFS_STATUS, d, r);
    chk("refused early", 32'h0000_0001, 32'(d[fop_pkg::ST_REFUSED]));
    rd(fop_pkg::OFS_IRQ_STAT, d, r);
    chk("irq status", 32'h0000_0002, d);
    chk("irq masked", 32'h0000_0000, 32'(irq));
    wr(fop_pkg::OFS_IRQ_MASK, 32'h0000_0003, fop_pkg::RESP_OKAY);
    rd(fop_pkg::OFS_IRQ_STAT, d, r);
    chk("irq raised", 32'h0000_0001, 32'(irq));
    wr(fop_pkg::OFS_IRQ_STAT, 32'h0000_0002, fop_pkg::RESP_OKAY);
    rd(fop_pkg::OFS_IRQ_STAT, d, r);
    chk("irq cleared", 32'h0000_0000, {d[31:1], irq});
    rd(8'h1c, d, r);
    chk("unmapped read", {30'h0000_0000, fop_pkg::RESP_SLVERR}, {d[29:0], r});
    wr(8'h06, 32'h0000_0000, fop_pkg::RESP_SLVERR);
    wait_ready();
    $display("test power-on done");
    cur = 3'h0;
    for (int i = 0; i < N_ROWS; i++) begin
      if (ROWS[i].o != cur) begin
        if (cur != 3'h0) go(3'h0, 3'h3, 32'h0000_0000, EXIT);
        go(ROWS[i].o, 3'h3, {6'h00, ROWS[i].a}, {ENTRY, 5'h00, ROWS[i].o});
        cur = ROWS[i].o;
      end
      go(cur, 3'h1, {6'h00, ROWS[i].a}, 16'h0000);
      chk("status flags", 32'(ROWS[i].f), 32'(d[3:2]));
      rd(fop_pkg::OFS_RDATA, d, r);
      if (!ROWS[i].f[0]) chk("read word", 32'(ROWS[i].d), d);
    end
    rd(fop_pkg::OFS_IRQ_STAT, d, r);
    chk("done flag", 32'h0000_0001, d);
    wr(fop_pkg::OFS_IRQ_STAT, 32'h0000_0001, fop_pkg::RESP_OKAY);
    $display("test overlays done");
    go(3'h0, 3'h3, 32'h8155_fd55, 16'h0000);
    chk("command address", 32'h0155_0555, {6'h00, we_addr});
    supply_low <= 1'b1;
    repeat (8) @(posedge core_clk);
    go(3'h0, 3'h3, 32'h0000_0000, 16'h0000);
    chk("low supply refused", 32'h0000_0001, 32'(d[fop_pkg::ST_REFUSED]));
    supply_low <= 1'b0;
    rd(fop_pkg::OFS_IRQ_STAT, d, r);
    chk("done and refused", 32'h0000_0003, d);
    wr(fop_pkg::OFS_IRQ_STAT, 32'h0000_0003, fop_pkg::RESP_OKAY);
    $display("test command format and lockout done");
    go(3'h1, 3'h3, 32'h0003_0000, {ENTRY, 8'h01});
    go(3'h7, 3'h1, 32'h0000_0030, 16'h0000);
    chk("ecc entry refused", 32'h0000_0001, 32'(d[fop_pkg::ST_REFUSED]));
    go(3'h0, 3'h4, 32'h0000_0000, 16'h0000);
    wait_ready();
    rd(fop_pkg::OFS_CTRL, d, r);
    chk("overlay after reset", 32'h0000_0000, 32'(d[6:4]));
    go(3'h0, 3'h1, 32'h0000_0123, 16'h0000);
    rd(fop_pkg::OFS_RDATA, d, r);
    chk("array after reset", 32'h0000_5b79, d);
    $display("test hardware reset done");
    conclude();
  end
endmodule
